// *** hdl/radio_tuning_agc_defines.svh ***
// register offsets, field positions, reset values and timing for the tuning/agc bank
`ifndef RADIO_TUNING_AGC_DEFINES_SVH
`define RADIO_TUNING_AGC_DEFINES_SVH

`define ADDR_W            10
`define OFS_AGC_CLK_DIV   10'h32F
`define OFS_FILT_OVR      10'h346
`define OFS_RC_CAL_HI     10'h34F
`define OFS_RC_CAL_LO     10'h350
`define OFS_ADC_IN_REF    10'h359
`define OFS_ADC_FILT_PWR  10'h35A
`define OFS_GAIN_ORDER    10'h35C
`define OFS_GAIN_MODE     10'h35D
`define OFS_GAIN_LOW      10'h35E
`define OFS_GAIN_HIGH     10'h35F
`define OFS_GAIN_READBACK 10'h360
`define OFS_ADC_READBACK  10'h361
`define OFS_FREQ_OFFSET   10'h372
`define OFS_BAND_VALUE    10'h3CB
`define OFS_BAND_ENABLE   10'h3CD

`define RST_AGC_CLK_DIV   8'h28
`define RST_FILT_OVR      8'h00
`define RST_ADC_IN_REF    8'h00
`define RST_ADC_FILT_PWR  8'h11
`define RST_GAIN_ORDER    8'h9C
`define RST_GAIN_MODE     8'h00
`define RST_GAIN_LOW      8'h37
`define RST_GAIN_HIGH     8'h69
`define RST_BAND_VALUE    8'h00
`define RST_BAND_ENABLE   8'h00

`define MASK_FILT_OVR     8'h7F
`define MASK_GAIN_MODE    8'h7F
`define MASK_BAND_ENABLE  8'h01

`define F_OVR_EN          0
`define F_ADC_PWR         4
`define F_ALLOW_XLOW      1
`define F_NO_MAX          0
`define F_BAND_EN         0

// agc tick: 26 MHz reference strobe divided by 16 x divider
`define AGC_PRESCALE      16
`define ADC_FILT_SHIFT    2
`define LNA_MAX           2'h2
`define MIX_MAX           2'h1
`define FLT_MAX           2'h2

`endif

// *** hdl/radio_tuning_agc_pkg.sv ***
// types shared by the tuning/agc register bank
package radio_tuning_agc_pkg;
  typedef enum logic [3:0] {
    AGC_FREE   = 4'h1,
    AGC_MANUAL = 4'h2,
    AGC_HOLD   = 4'h4,
    AGC_LOCK   = 4'h8
  } agc_op_t;
  typedef enum logic [1:0] {
    FILT_NONE     = 2'h0,
    FILT_ON_READ  = 2'h1,
    FILT_ON_TICK  = 2'h2,
    FILT_BOTH     = 2'h3
  } adc_filt_mode_t;
endpackage

// *** hdl/gain_update_clock_divider.sv ***
// agc update strobe: reference strobes divided by prescale x programmable divide
`timescale 1ns/1ps
`include "radio_tuning_agc_defines.svh"
module gain_update_clock_divider #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // control
  input  wire logic             ref_tick,
  input  wire logic [DIV_W-1:0] divide,
  // strobe out
  output logic                  tick_r
);
  localparam int CNT_W = DIV_W + 4;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] limit;
  logic             tick_nxt;

  always_comb begin
    limit    = CNT_W'(`AGC_PRESCALE) * {4'h0, divide};
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    // divide of zero stops the agc clock rather than wrapping
    if (ref_tick && divide != '0) begin
      if (cnt_r >= limit - CNT_W'(1)) begin
        cnt_nxt  = '0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
endmodule // gain_update_clock_divider

// *** hdl/adc_sample_filter.sv ***
// first-order smoothing of the adc samples, stepped by the agc strobe
`timescale 1ns/1ps
`include "radio_tuning_agc_defines.svh"
module adc_sample_filter #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // samples
  input  wire logic         step,
  input  wire logic [W-1:0] sample,
  // smoothed value
  output logic      [W-1:0] avg_r
);
  // extra fraction bits keep small steps from being lost
  logic [W+1:0] acc_r;
  logic [W+1:0] acc_nxt;

  always_comb begin
    acc_nxt = acc_r;
    if (step) begin
      acc_nxt = acc_r - (acc_r >> `ADC_FILT_SHIFT)
              + (W+2)'({2'b00, sample});
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_r <= '0;
      avg_r <= '0;
    end else begin
      acc_r <= acc_nxt;
      avg_r <= acc_nxt[W+1:2];
    end
  end
endmodule // adc_sample_filter

// *** hdl/radio_tuning_agc_register_bank.sv ***
// tuning, adc and agc control register bank with the agc gain stepper
//
// Function
// - override enable set: six-bit override word replaces calibrated filter word
// - rc oscillator 16-bit cal result read as high and low bytes, taken live from rc_osc_cal_result
// - adc input select 0 rssi, 1 external, 2 temperature; reference level field
// - adc filter mode chooses raw or filtered loop and readback refresh
// - adc reference enable resets to one; zero powers reference down
// - three gain order fields for lna, mixer, filter reset to 2, 1, 3
// - extra low lna bit allows one more lower lna step
// - disallow max bit keeps agc off its highest overall gain
// - agc operation: free run, manual, hold, lock after preamble
// - frequency error byte is signed, one step per kHz
// - band override value replaces calibrated band only while enabled
// - agc clock is reference over sixteen times divide, divide resets to 40
// - band override enable bit turns the override on and off
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "radio_tuning_agc_defines.svh"
module radio_tuning_agc_register_bank #(
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // register port
  input  wire logic [`ADDR_W-1:0] reg_addr,
  input  wire logic [DW-1:0]     reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DW-1:0]     reg_rdata_r,
  // calibration and measurement inputs
  input  wire logic [5:0]        filter_cal_word_in,
  input  wire logic [15:0]       rc_osc_cal_result,
  input  wire logic [DW-1:0]     freq_error_in,
  input  wire logic [DW-1:0]     osc_band_cal_in,
  input  wire logic [DW-1:0]     adc_sample,
  input  wire logic              ref_tick,
  input  wire logic              preamble_detected,
  // analog control outputs
  output logic      [5:0]        filter_cal_word_r,
  output logic      [1:0]        adc_input_select_r,
  output logic      [1:0]        adc_reference_level_r,
  output logic                   adc_reference_power_enable_r,
  output logic      [DW-1:0]     osc_band_r,
  output logic      [1:0]        front_amp_gain_now_r,
  output logic                   front_amp_extra_low_r,
  output logic                   mixer_gain_now_r,
  output logic      [1:0]        filter_gain_now_r
);
  // software registers
  logic [DW-1:0] clk_div_r, filt_ovr_r, adc_in_ref_r, adc_filt_pwr_r;
  logic [DW-1:0] order_r, mode_r, low_r, high_r, band_val_r, band_en_r;
  logic [DW-1:0] clk_div_nxt, filt_ovr_nxt, adc_in_ref_nxt, adc_filt_pwr_nxt;
  logic [DW-1:0] order_nxt, mode_nxt, low_nxt, high_nxt, band_val_nxt, band_en_nxt;
  logic [DW-1:0] rdata_nxt;

  // agc and adc state
  logic [1:0]    lna_r, lna_nxt, flt_r, flt_nxt;
  logic          mix_r, mix_nxt, xlow_r, xlow_nxt;
  logic          locked_r, locked_nxt;
  logic [DW-1:0] adc_rb_r, adc_rb_nxt;
  logic [DW-1:0] adc_avg;
  logic          agc_tick;
  logic [DW-1:0] loop_level;
  logic [DW-1:0] rb_view;
  logic          rb_read;
  logic          up_req, dn_req;
  logic          at_max_next;
  logic [1:0]    up_sel, dn_sel;
  radio_tuning_agc_pkg::agc_op_t        op;
  radio_tuning_agc_pkg::adc_filt_mode_t fmode;

  gain_update_clock_divider #(
    .DIV_W (DW)
  ) u_div (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .ref_tick(ref_tick),
    .divide  (clk_div_r),
    .tick_r  (agc_tick)
  );

  adc_sample_filter #(
    .W (DW)
  ) u_filt (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .step   (agc_tick),
    .sample (adc_sample),
    .avg_r  (adc_avg)
  );

  // decode of mode fields
  always_comb begin
    unique case (mode_r[6:5])
      2'h0: op = radio_tuning_agc_pkg::AGC_FREE;
      2'h1: op = radio_tuning_agc_pkg::AGC_MANUAL;
      2'h2: op = radio_tuning_agc_pkg::AGC_HOLD;
      2'h3: op = radio_tuning_agc_pkg::AGC_LOCK;
    endcase
    fmode   = radio_tuning_agc_pkg::adc_filt_mode_t'(adc_filt_pwr_r[6:5]);
    rb_read = reg_rd && reg_addr == `OFS_ADC_READBACK;
  end

  // register writes
  always_comb begin
    clk_div_nxt      = clk_div_r;
    filt_ovr_nxt     = filt_ovr_r;
    adc_in_ref_nxt   = adc_in_ref_r;
    adc_filt_pwr_nxt = adc_filt_pwr_r;
    order_nxt        = order_r;
    mode_nxt         = mode_r;
    low_nxt          = low_r;
    high_nxt         = high_r;
    band_val_nxt     = band_val_r;
    band_en_nxt      = band_en_r;
    if (reg_wr) begin
      unique case (reg_addr)
        `OFS_AGC_CLK_DIV:  clk_div_nxt      = reg_wdata;
        `OFS_FILT_OVR:     filt_ovr_nxt     = reg_wdata & `MASK_FILT_OVR;
        `OFS_ADC_IN_REF:   adc_in_ref_nxt   = reg_wdata;
        `OFS_ADC_FILT_PWR: adc_filt_pwr_nxt = reg_wdata;
        `OFS_GAIN_ORDER:   order_nxt        = reg_wdata;
        `OFS_GAIN_MODE:    mode_nxt         = reg_wdata & `MASK_GAIN_MODE;
        `OFS_GAIN_LOW:     low_nxt          = reg_wdata;
        `OFS_GAIN_HIGH:    high_nxt         = reg_wdata;
        `OFS_BAND_VALUE:   band_val_nxt     = reg_wdata;
        `OFS_BAND_ENABLE:  band_en_nxt      = reg_wdata & `MASK_BAND_ENABLE;
        default: ;
      endcase
    end
  end

  // adc readback and the level the agc loop sees
  always_comb begin
    adc_rb_nxt = adc_rb_r;
    loop_level = adc_sample;
    unique case (fmode)
      radio_tuning_agc_pkg::FILT_NONE:    adc_rb_nxt = adc_sample;
      radio_tuning_agc_pkg::FILT_ON_READ: if (rb_read) adc_rb_nxt = adc_avg;
      radio_tuning_agc_pkg::FILT_ON_TICK: if (agc_tick) adc_rb_nxt = adc_avg;
      radio_tuning_agc_pkg::FILT_BOTH: begin
        adc_rb_nxt = adc_avg;
        loop_level = adc_avg;
      end
    endcase
    // mode 01 shows the value caught by the previous read
    rb_view = adc_rb_r;
  end

  // gain stepping: raise the stage with lowest order code first, lower the highest
  always_comb begin
    up_sel = 2'h3;
    dn_sel = 2'h3;
    // stages: 0 lna, 1 mixer, 2 filter; 3 means none can move
    for (int s = 0; s < 3; s++) begin
      logic [1:0] code_s, code_u, code_d;
      logic       can_up, can_dn;
      can_up = 1'b0;
      can_dn = 1'b0;
      code_s = order_r[7-2*s -: 2];
      code_u = (up_sel == 2'h3) ? 2'h3 : order_r[7-2*up_sel -: 2];
      code_d = (dn_sel == 2'h3) ? 2'h0 : order_r[7-2*dn_sel -: 2];
      unique case (s)
        0: begin
          can_up = xlow_r || lna_r < `LNA_MAX;
          can_dn = lna_r != 2'h0 || (order_r[`F_ALLOW_XLOW] && !xlow_r);
        end
        1: begin
          can_up = !mix_r;
          can_dn = mix_r;
        end
        default: begin
          can_up = flt_r < `FLT_MAX;
          can_dn = flt_r != 2'h0;
        end
      endcase
      if (can_up && (up_sel == 2'h3 || code_s <= code_u)) up_sel = 2'(s);
      if (can_dn && (dn_sel == 2'h3 || code_s >= code_d)) dn_sel = 2'(s);
    end
  end

  // agc gain state
  always_comb begin
    lna_nxt    = lna_r;
    mix_nxt    = mix_r;
    flt_nxt    = flt_r;
    xlow_nxt   = xlow_r;
    locked_nxt = locked_r;
    up_req     = loop_level < low_r;
    dn_req     = loop_level > high_r;
    // are all stages but the one a raise would pick already at full gain
    at_max_next = !xlow_r
      && (lna_r == `LNA_MAX || up_sel == 2'h0)
      && (mix_r || up_sel == 2'h1)
      && (flt_r == `FLT_MAX || up_sel == 2'h2);
    if (op != radio_tuning_agc_pkg::AGC_LOCK) begin
      locked_nxt = 1'b0;
    end else if (preamble_detected) begin
      locked_nxt = 1'b1;
    end
    unique case (op)
      radio_tuning_agc_pkg::AGC_MANUAL: begin
        lna_nxt  = mode_r[4:3];
        mix_nxt  = mode_r[2];
        flt_nxt  = mode_r[1:0];
        xlow_nxt = 1'b0;
      end
      radio_tuning_agc_pkg::AGC_HOLD: ;
      radio_tuning_agc_pkg::AGC_FREE, radio_tuning_agc_pkg::AGC_LOCK: begin
        if (agc_tick && !locked_r) begin
          if (up_req && up_sel != 2'h3
              && !(order_r[`F_NO_MAX] && at_max_next)) begin
            unique case (up_sel)
              2'h0: if (xlow_r) xlow_nxt = 1'b0;
                    else lna_nxt = lna_r + 2'h1;
              2'h1: mix_nxt = 1'b1;
              default: flt_nxt = flt_r + 2'h1;
            endcase
          end else if (dn_req && dn_sel != 2'h3) begin
            unique case (dn_sel)
              2'h0: if (lna_r == 2'h0) xlow_nxt = 1'b1;
                    else lna_nxt = lna_r - 2'h1;
              2'h1: mix_nxt = 1'b0;
              default: flt_nxt = flt_r - 2'h1;
            endcase
          end
        end
      end
    endcase
    // clearing the allow bit pulls the lna out of its extra low step
    if (!order_r[`F_ALLOW_XLOW]) xlow_nxt = 1'b0;
  end

  // read mux, answered in the next cycle only
  always_comb begin
    rdata_nxt = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `OFS_AGC_CLK_DIV:   rdata_nxt = clk_div_r;
        `OFS_FILT_OVR:      rdata_nxt = filt_ovr_r;
        `OFS_RC_CAL_HI:     rdata_nxt = rc_osc_cal_result[15:8];
        `OFS_RC_CAL_LO:     rdata_nxt = rc_osc_cal_result[7:0];
        `OFS_ADC_IN_REF:    rdata_nxt = adc_in_ref_r;
        `OFS_ADC_FILT_PWR:  rdata_nxt = adc_filt_pwr_r;
        `OFS_GAIN_ORDER:    rdata_nxt = order_r;
        `OFS_GAIN_MODE:     rdata_nxt = mode_r;
        `OFS_GAIN_LOW:      rdata_nxt = low_r;
        `OFS_GAIN_HIGH:     rdata_nxt = high_r;
        `OFS_GAIN_READBACK: rdata_nxt = {3'h0, lna_r, mix_r, flt_r};
        `OFS_ADC_READBACK:  rdata_nxt = rb_view;
        `OFS_FREQ_OFFSET:   rdata_nxt = freq_error_in;
        `OFS_BAND_VALUE:    rdata_nxt = band_val_r;
        `OFS_BAND_ENABLE:   rdata_nxt = band_en_r;
        default:            rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      clk_div_r      <= `RST_AGC_CLK_DIV;
      filt_ovr_r     <= `RST_FILT_OVR;
      adc_in_ref_r   <= `RST_ADC_IN_REF;
      adc_filt_pwr_r <= `RST_ADC_FILT_PWR;
      order_r        <= `RST_GAIN_ORDER;
      mode_r         <= `RST_GAIN_MODE;
      low_r          <= `RST_GAIN_LOW;
      high_r         <= `RST_GAIN_HIGH;
      band_val_r     <= `RST_BAND_VALUE;
      band_en_r      <= `RST_BAND_ENABLE;
      reg_rdata_r    <= '0;
      lna_r          <= 2'h0;
      mix_r          <= 1'b0;
      flt_r          <= 2'h0;
      xlow_r         <= 1'b0;
      locked_r       <= 1'b0;
      adc_rb_r       <= '0;
    end else begin
      clk_div_r      <= clk_div_nxt;
      filt_ovr_r     <= filt_ovr_nxt;
      adc_in_ref_r   <= adc_in_ref_nxt;
      adc_filt_pwr_r <= adc_filt_pwr_nxt;
      order_r        <= order_nxt;
      mode_r         <= mode_nxt;
      low_r          <= low_nxt;
      high_r         <= high_nxt;
      band_val_r     <= band_val_nxt;
      band_en_r      <= band_en_nxt;
      reg_rdata_r    <= rdata_nxt;
      lna_r          <= lna_nxt;
      mix_r          <= mix_nxt;
      flt_r          <= flt_nxt;
      xlow_r         <= xlow_nxt;
      locked_r       <= locked_nxt;
      adc_rb_r       <= adc_rb_nxt;
    end
  end

  // analog control outputs, registered one cycle after their source
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      filter_cal_word_r            <= 6'h00;
      adc_input_select_r           <= 2'h0;
      adc_reference_level_r        <= 2'h0;
      adc_reference_power_enable_r <= 1'b1;
      osc_band_r                   <= '0;
      front_amp_gain_now_r         <= 2'h0;
      front_amp_extra_low_r        <= 1'b0;
      mixer_gain_now_r             <= 1'b0;
      filter_gain_now_r            <= 2'h0;
    end else begin
      filter_cal_word_r            <= filt_ovr_r[`F_OVR_EN] ? filt_ovr_r[6:1]
                                                            : filter_cal_word_in;
      adc_input_select_r           <= adc_in_ref_r[3:2];
      adc_reference_level_r        <= adc_in_ref_r[1:0];
      adc_reference_power_enable_r <= adc_filt_pwr_r[`F_ADC_PWR];
      osc_band_r                   <= band_en_r[`F_BAND_EN] ? band_val_r
                                                            : osc_band_cal_in;
      front_amp_gain_now_r         <= lna_r;
      front_amp_extra_low_r        <= xlow_r;
      mixer_gain_now_r             <= mix_r;
      filter_gain_now_r            <= flt_r;
    end
  end
endmodule // radio_tuning_agc_register_bank

// *** verif/radio_tuning_agc_register_bank_sva.sv ***
// port assertions for the tuning/agc register bank
`timescale 1ns/1ps
`include "radio_tuning_agc_defines.svh"
module radio_tuning_agc_register_bank_sva #(
  parameter int DW = 8
) (
  // clock and reset
  input wire logic                clk_sys,
  input wire logic                sys_rst,
  // register port
  input wire logic [`ADDR_W-1:0]  reg_addr,
  input wire logic [DW-1:0]       reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [DW-1:0]       reg_rdata_r,
  // live inputs
  input wire logic [5:0]          filter_cal_word_in,
  input wire logic [15:0]         rc_osc_cal_result,
  input wire logic [DW-1:0]       freq_error_in,
  input wire logic [DW-1:0]       osc_band_cal_in,
  // control outputs
  input wire logic [5:0]          filter_cal_word_r,
  input wire logic [1:0]          adc_input_select_r,
  input wire logic [1:0]          adc_reference_level_r,
  input wire logic                adc_reference_power_enable_r,
  input wire logic [DW-1:0]       osc_band_r,
  input wire logic [1:0]          front_amp_gain_now_r,
  input wire logic                mixer_gain_now_r,
  input wire logic [1:0]          filter_gain_now_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire logic wr_filt = reg_wr && reg_addr == `OFS_FILT_OVR;
  wire logic wr_mode = reg_wr && reg_addr == `OFS_GAIN_MODE;

  property p_filt_ovr;
    wr_filt && reg_wdata[0] |=> ##1 filter_cal_word_r == $past(reg_wdata[6:1], 2);
  endproperty
  a_filt_ovr: assert property (p_filt_ovr) else $error("override word not applied");
  property p_filt_cal;
    wr_filt && !reg_wdata[0] |=> ##1 filter_cal_word_r == $past(filter_cal_word_in);
  endproperty
  a_filt_cal: assert property (p_filt_cal) else $error("calibrated word not used");
  property p_rc_hi;
    reg_rd && reg_addr == `OFS_RC_CAL_HI |=> reg_rdata_r == $past(rc_osc_cal_result[15:8]);
  endproperty
  a_rc_hi: assert property (p_rc_hi) else $error("rc result high byte wrong");
  property p_rc_lo;
    reg_rd && reg_addr == `OFS_RC_CAL_LO |=> reg_rdata_r == $past(rc_osc_cal_result[7:0]);
  endproperty
  a_rc_lo: assert property (p_rc_lo) else $error("rc result low byte wrong");
  property p_freq;
    reg_rd && reg_addr == `OFS_FREQ_OFFSET |=> reg_rdata_r == $past(freq_error_in);
  endproperty
  a_freq: assert property (p_freq) else $error("frequency error byte wrong");
  property p_pwr_rst;
    $fell(sys_rst) |-> adc_reference_power_enable_r;
  endproperty
  a_pwr_rst: assert property (p_pwr_rst) else $error("reference enable not one after reset");
  property p_pwr_wr;
    reg_wr && reg_addr == `OFS_ADC_FILT_PWR
      |=> ##1 adc_reference_power_enable_r == $past(reg_wdata[4], 2);
  endproperty
  a_pwr_wr: assert property (p_pwr_wr) else $error("reference enable not applied");
  property p_adc_sel;
    reg_wr && reg_addr == `OFS_ADC_IN_REF
      |=> ##1 {adc_input_select_r, adc_reference_level_r} == $past(reg_wdata[3:0], 2);
  endproperty
  a_adc_sel: assert property (p_adc_sel) else $error("adc select or level wrong");
  property p_band_off;
    reg_wr && reg_addr == `OFS_BAND_ENABLE && !reg_wdata[0]
      |=> ##1 osc_band_r == $past(osc_band_cal_in);
  endproperty
  a_band_off: assert property (p_band_off) else $error("band not calibrated value");
  property p_manual;
    wr_mode && reg_wdata[6:5] == 2'h1 && reg_wdata[4:3] != 2'h3 && reg_wdata[1:0] != 2'h3
      |=> ##2 {front_amp_gain_now_r, mixer_gain_now_r, filter_gain_now_r}
        == $past(reg_wdata[4:0], 3);
  endproperty
  a_manual: assert property (p_manual) else $error("manual gains not applied");
  property p_rd_idle;
    !reg_rd |=> reg_rdata_r == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
endmodule // radio_tuning_agc_register_bank_sva

bind radio_tuning_agc_register_bank radio_tuning_agc_register_bank_sva #(.DW(DW)) u_sva (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
  .filter_cal_word_in(filter_cal_word_in), .rc_osc_cal_result(rc_osc_cal_result),
  .freq_error_in(freq_error_in), .osc_band_cal_in(osc_band_cal_in),
  .filter_cal_word_r(filter_cal_word_r), .adc_input_select_r(adc_input_select_r),
  .adc_reference_level_r(adc_reference_level_r),
  .adc_reference_power_enable_r(adc_reference_power_enable_r), .osc_band_r(osc_band_r),
  .front_amp_gain_now_r(front_amp_gain_now_r), .mixer_gain_now_r(mixer_gain_now_r),
  .filter_gain_now_r(filter_gain_now_r));

// *** verif/radio_tuning_agc_register_bank_bench.sv ***
// self-checking bench for the tuning/agc register bank
`timescale 1ns/1ps
`include "radio_tuning_agc_defines.svh"
module radio_tuning_agc_register_bank_bench;
  typedef struct packed {
    logic       wr;
    logic [9:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  logic        clk_sys, sys_rst, reg_wr, reg_rd, ref_tick, preamble_detected;
  logic        pwr_en, xlow, mix_g;
  logic [9:0]  reg_addr;
  logic [7:0]  reg_wdata, rdata, freq_err, band_cal, adc_sample, band, rb;
  logic [5:0]  filt_in, filt_out;
  logic [15:0] rc_res;
  logic [1:0]  in_sel, ref_lvl, lna_g, flt_g;
  logic [4:0]  g;
  int          failures, checks_done;
  int          cycles = 0;
  // thresholds go in before the order byte so the stepper stays quiet meanwhile
  row_t rows [29] = '{
    '{1'h0, 10'h32F, 8'h00, 8'h28}, '{1'h0, 10'h346, 8'h00, 8'h00}, '{1'h0, 10'h34F, 8'h00, 8'h00},
    '{1'h0, 10'h350, 8'h00, 8'h00}, '{1'h0, 10'h359, 8'h00, 8'h00}, '{1'h0, 10'h35A, 8'h00, 8'h11},
    '{1'h0, 10'h35C, 8'h00, 8'h9C}, '{1'h0, 10'h35D, 8'h00, 8'h00}, '{1'h0, 10'h35E, 8'h00, 8'h37},
    '{1'h0, 10'h35F, 8'h00, 8'h69}, '{1'h0, 10'h360, 8'h00, 8'h00}, '{1'h0, 10'h372, 8'h00, 8'h00},
    '{1'h0, 10'h3CB, 8'h00, 8'h00}, '{1'h0, 10'h3CD, 8'h00, 8'h00}, '{1'h1, 10'h35E, 8'h12, 8'h12},
    '{1'h1, 10'h35F, 8'hC8, 8'hC8}, '{1'h1, 10'h32F, 8'h01, 8'h01}, '{1'h1, 10'h346, 8'hFF, 8'h7F},
    '{1'h1, 10'h359, 8'hA5, 8'hA5}, '{1'h1, 10'h35A, 8'h91, 8'h91}, '{1'h1, 10'h35C, 8'h3F, 8'h3F},
    '{1'h1, 10'h3CB, 8'h5A, 8'h5A}, '{1'h1, 10'h3CD, 8'hFF, 8'h01}, '{1'h1, 10'h34F, 8'hFF, 8'h00},
    '{1'h1, 10'h350, 8'hFF, 8'h00}, '{1'h1, 10'h360, 8'hFF, 8'h00}, '{1'h1, 10'h372, 8'hFF, 8'h00},
    '{1'h1, 10'h300, 8'hFF, 8'h00}, '{1'h1, 10'h3FF, 8'h55, 8'h00}};

  radio_tuning_agc_register_bank u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(rdata), .filter_cal_word_in(filt_in),
    .rc_osc_cal_result(rc_res), .freq_error_in(freq_err), .osc_band_cal_in(band_cal),
    .adc_sample(adc_sample), .ref_tick(ref_tick), .preamble_detected(preamble_detected),
    .filter_cal_word_r(filt_out), .adc_input_select_r(in_sel), .adc_reference_level_r(ref_lvl),
    .adc_reference_power_enable_r(pwr_en), .osc_band_r(band), .front_amp_gain_now_r(lna_g),
    .front_amp_extra_low_r(xlow), .mixer_gain_now_r(mix_g), .filter_gain_now_r(flt_g));

  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic summarize;
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [9:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 rb = rdata;
    @(posedge clk_sys);
  endtask

  // manual gains pass mode, gain state and output: two edges after the write
  task automatic lag;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_agc;
    repeat (200) @(posedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      summarize;
    end
  end

  initial begin
    sys_rst = 1'h1;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 10'h000;
    reg_wdata = 8'h00;
    filt_in = 6'h11;
    rc_res = 16'h0000;
    freq_err = 8'h00;
    band_cal = 8'hC3;
    adc_sample = 8'h80;
    ref_tick = 1'h1;
    preamble_detected = 1'h0;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'h0;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(rb, rows[i].e);
    end
    rc_res <= 16'hA53C;
    freq_err <= 8'hF6;
    rd(`OFS_RC_CAL_HI);
    chk(rb, 8'hA5);
    rd(`OFS_RC_CAL_LO);
    chk(rb, 8'h3C);
    rd(`OFS_FREQ_OFFSET);
    chk(rb, 8'hF6);
    wr(`OFS_FILT_OVR, 8'h57);
    lag;
    chk({2'h0, filt_out}, 8'h2B);
    wr(`OFS_FILT_OVR, 8'h56);
    lag;
    chk({2'h0, filt_out}, 8'h11);
    chk(band, 8'h5A);
    wr(`OFS_BAND_ENABLE, 8'h00);
    lag;
    chk(band, 8'hC3);
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_ADC_IN_REF, {4'h0, i[1:0], ~i[1:0]});
      lag;
      chk({4'h0, in_sel, ref_lvl}, {4'h0, i[1:0], ~i[1:0]});
    end
    wr(`OFS_ADC_FILT_PWR, 8'h01);
    lag;
    chk({7'h0, pwr_en}, 8'h00);
    wr(`OFS_ADC_FILT_PWR, 8'h11);
    for (int i = 0; i < 3; i++) begin
      g = {i[1:0], i[0], 2'(2 - i)};
      wr(`OFS_GAIN_MODE, {3'h1, g});
      lag;
      chk({3'h0, lna_g, mix_g, flt_g}, {3'h0, g});
      rd(`OFS_GAIN_READBACK);
      chk(rb, {3'h0, g});
    end
    // hold freezes low gains even with a weak signal
    wr(`OFS_GAIN_ORDER, 8'h9C);
    wr(`OFS_GAIN_MODE, 8'h20);
    adc_sample <= 8'h00;
    wr(`OFS_GAIN_MODE, 8'h40);
    wait_agc;
    rd(`OFS_GAIN_READBACK);
    chk(rb, 8'h00);
    wr(`OFS_GAIN_MODE, 8'h00);
    wait_agc;
    rd(`OFS_GAIN_READBACK);
    chk(rb, 8'h16);
    adc_sample <= 8'hFF;
    wait_agc;
    rd(`OFS_GAIN_READBACK);
    chk(rb, 8'h00);
    chk({7'h0, xlow}, 8'h00);
    wr(`OFS_GAIN_ORDER, 8'h9E);
    wait_agc;
    chk({7'h0, xlow}, 8'h01);
    wr(`OFS_GAIN_ORDER, 8'h9D);
    adc_sample <= 8'h00;
    wait_agc;
    rd(`OFS_GAIN_READBACK);
    chk({7'h0, rb !== 8'h16}, 8'h01);
    wr(`OFS_GAIN_MODE, 8'h20);
    adc_sample <= 8'h80;
    wr(`OFS_GAIN_MODE, 8'h60);
    @(posedge clk_sys);
    preamble_detected <= 1'h1;
    @(posedge clk_sys);
    preamble_detected <= 1'h0;
    adc_sample <= 8'h00;
    wait_agc;
    rd(`OFS_GAIN_READBACK);
    chk(rb, 8'h00);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'h0;
    #1 chk({7'h0, pwr_en}, 8'h01);
    rd(`OFS_GAIN_ORDER);
    chk(rb, 8'h9C);
    rd(`OFS_AGC_CLK_DIV);
    chk(rb, 8'h28);
    // reset mode 00 reads the raw sample; no agc tick yet since reset, so the filtered readbacks are still zero
    adc_sample <= 8'h5A;
    rd(`OFS_ADC_READBACK);
    chk(rb, 8'h5A);
    wr(`OFS_ADC_FILT_PWR, 8'h71);
    rd(`OFS_ADC_READBACK);
    chk(rb, 8'h00);
    wr(`OFS_ADC_FILT_PWR, 8'h51);
    rd(`OFS_ADC_READBACK);
    chk(rb, 8'h00);
    summarize;
  end
endmodule // radio_tuning_agc_register_bank_bench
